/* hw/ppde_pkg.sv */
// package for the eight-pin port drive and edge interrupt block
package ppde_pkg;
  localparam int NPIN = 8;
  localparam int NOE  = 16;
  localparam int AW   = 6;
  localparam int DW   = 8;
  // register offsets
  localparam logic [AW-1:0] OFF_DR    = 6'h00;
  localparam logic [AW-1:0] OFF_DM0   = 6'h01;
  localparam logic [AW-1:0] OFF_DM1   = 6'h02;
  localparam logic [AW-1:0] OFF_DM2   = 6'h03;
  localparam logic [AW-1:0] OFF_SLW   = 6'h04;
  localparam logic [AW-1:0] OFF_BYP   = 6'h05;
  localparam logic [AW-1:0] OFF_BIE   = 6'h06;
  localparam logic [AW-1:0] OFF_IBD   = 6'h07;
  localparam logic [AW-1:0] OFF_IEN0  = 6'h08;
  localparam logic [AW-1:0] OFF_IEN1  = 6'h09;
  localparam logic [AW-1:0] OFF_STAT  = 6'h0A;
  localparam logic [AW-1:0] OFF_PS    = 6'h0B;
  localparam logic [AW-1:0] OFF_CTL   = 6'h0C;
  localparam logic [AW-1:0] OFF_RSTCF = 6'h0D;
  localparam logic [AW-1:0] OFF_SIO   = 6'h0E;
  localparam logic [AW-1:0] OFF_OESEL = 6'h10;
  localparam logic [AW-1:0] OFF_PIN   = 6'h20;
  // per-pin form: [2:0] mode, 3 data, 4 slew, 5 bypass, 6 in-dis, 7 bidir
  localparam int PF_DM  = 0;
  localparam int PF_DR  = 3;
  localparam int PF_SLW = 4;
  localparam int PF_BYP = 5;
  localparam int PF_IBD = 6;
  localparam int PF_BIE = 7;
  // control register fields
  localparam int CTL_LVTTL = 0;
  // reset configuration field: 0 analog, 1 pull-down, 2 pull-up
  localparam logic [1:0] RC_PD = 2'h1;
  localparam logic [1:0] RC_PU = 2'h2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef enum logic [2:0] {
    DM_HIZ_ANA = 3'b000,
    DM_HIZ_DIG = 3'b001,
    DM_RES_UP  = 3'b010,
    DM_RES_DN  = 3'b011,
    DM_OD_LO   = 3'b100,
    DM_OD_HI   = 3'b101,
    DM_STRONG  = 3'b110,
    DM_RES_UD  = 3'b111
  } ppde_mode_e;
  // edge select
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage : ppde_pkg

/* hw/ppde_pin_drive.sv */
// one pin's drive decode from mode, data and output enable
module ppde_pin_drive
  import ppde_pkg::*;
(
  // configuration
  input  wire logic [2:0] mode_i,
  input  wire logic       data_i,
  input  wire logic       bidir_i,
  input  wire logic       oe_i,
  input  wire logic       ibuf_dis_i,
  input  wire logic       slow_i,
  input  wire logic       reg_out_i,
  // drive result
  output logic            strong_hi_o,
  output logic            strong_lo_o,
  output logic            res_hi_o,
  output logic            res_lo_o,
  output logic            in_en_o,
  output logic            slow_o
);
  logic [2:0] eff;
  always_comb
  begin
    eff = mode_i;
    if (bidir_i && !oe_i)
      eff = DM_HIZ_DIG;
    // resistive modes dropped in regulated output mode
    if (reg_out_i && (eff == DM_RES_UP || eff == DM_RES_DN ||
                      eff == DM_RES_UD))
      eff = DM_HIZ_DIG;
    strong_hi_o = 1'b0;
    strong_lo_o = 1'b0;
    res_hi_o    = 1'b0;
    res_lo_o    = 1'b0;
    case (eff)
      DM_HIZ_ANA: ;
      DM_HIZ_DIG: ;
      DM_RES_UP:
      begin
        res_hi_o    = data_i;
        strong_lo_o = !data_i;
      end
      DM_RES_DN:
      begin
        strong_hi_o = data_i;
        res_lo_o    = !data_i;
      end
      DM_OD_LO:  strong_lo_o = !data_i;
      DM_OD_HI:  strong_hi_o = data_i;
      DM_STRONG:
      begin
        strong_hi_o = data_i;
        strong_lo_o = !data_i;
      end
      DM_RES_UD:
      begin
        res_hi_o = data_i;
        res_lo_o = !data_i;
      end
      default: ;
    endcase
    in_en_o = (eff != DM_HIZ_ANA) && !ibuf_dis_i;
    // slew only matters for strong and open drain
    slow_o  = slow_i && (eff == DM_OD_LO || eff == DM_OD_HI ||
                         eff == DM_STRONG) &&
              (strong_hi_o || strong_lo_o);
  end
endmodule : ppde_pin_drive

/* hw/ppde_port.sv */
// eight-pin port: drive modes, registers, edge interrupt unit
//
// Decided for this implementation: the register addresses and the plain strobed port.
module ppde_port
  import ppde_pkg::*;
(
  // clock and reset
  input  wire logic                       REF_CLK_I,
  input  wire logic                       RESETN_I,
  // register port
  input  wire logic [ppde_pkg::AW-1:0]    ADDR_I,
  input  wire logic [ppde_pkg::DW-1:0]    WDATA_I,
  input  wire logic                       WR_I,
  input  wire logic                       RD_I,
  output logic      [ppde_pkg::DW-1:0]    RDATA_O,
  // stored reset configuration, two bits per pin
  input  wire logic [2*ppde_pkg::NPIN-1:0] NV_RSTCFG_I,
  // internal logic signals
  input  wire logic [ppde_pkg::NPIN-1:0]  BYPASS_DATA_I,
  input  wire logic [ppde_pkg::NOE-1:0]   AUX_OE_I,
  // pins
  input  wire logic [ppde_pkg::NPIN-1:0]  PIN_I,
  output logic      [ppde_pkg::NPIN-1:0]  STRONG_HI_O,
  output logic      [ppde_pkg::NPIN-1:0]  STRONG_LO_O,
  output logic      [ppde_pkg::NPIN-1:0]  RES_HI_O,
  output logic      [ppde_pkg::NPIN-1:0]  RES_LO_O,
  output logic      [ppde_pkg::NPIN-1:0]  SLOW_O,
  output logic                            LVTTL_O,
  // digital input to internal logic
  output logic      [ppde_pkg::NPIN-1:0]  PIN_DATA_O,
  // interrupt request
  output logic                            PORT_IRQ_O
);
  import ppde_pkg::*;

  logic [NPIN-1:0] port_output_data_reg;
  logic [NPIN-1:0] port_drive_mode_reg [3];
  logic [NPIN-1:0] port_slew_select_reg;
  logic [NPIN-1:0] byp;
  logic [NPIN-1:0] bidir;
  logic [NPIN-1:0] ibuf_dis;
  logic [NPIN-1:0] ien0;
  logic [NPIN-1:0] ien1;
  logic [NPIN-1:0] stat;
  logic [NPIN-1:0] reg_out;
  logic [7:0]      ctl;
  logic [2*NPIN-1:0] rstcfg;
  logic [3:0]      oe_sel [NPIN];
  logic            loaded;
  logic [NPIN-1:0] in_en;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_qq;
  logic [NPIN-1:0] sh;
  logic [NPIN-1:0] sl;
  logic [NPIN-1:0] rh;
  logic [NPIN-1:0] rl;
  logic [NPIN-1:0] sw;
  logic [NPIN-1:0] edge_hit;
  logic [NPIN-1:0] next_stat;
  logic            pin_sel;
  logic [2:0]      pin_idx;
  logic            stat_rd;
  logic [DW-1:0]   next_rdata;

  assign pin_sel = WR_I && (ADDR_I[5:3] == OFF_PIN[5:3]);
  assign pin_idx = ADDR_I[2:0];
  assign stat_rd = RD_I && (ADDR_I == OFF_STAT);

  // port-form and pin-form writes land in the same bits
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      port_output_data_reg   <= RESET_BYTE;
      port_drive_mode_reg[0] <= RESET_BYTE;
      port_drive_mode_reg[1] <= RESET_BYTE;
      port_drive_mode_reg[2] <= RESET_BYTE;
      port_slew_select_reg   <= RESET_BYTE;
      byp                    <= RESET_BYTE;
      bidir                  <= RESET_BYTE;
      ibuf_dis               <= RESET_BYTE;
      reg_out                <= RESET_BYTE;
      ctl                    <= RESET_BYTE;
      loaded                 <= 1'b0;
    end
    else if (!loaded)
    begin
      // stored reset state applied once after release
      loaded <= 1'b1;
      for (int i = 0; i < NPIN; i++)
      begin
        // taken from the input: rstcfg only fills on this same edge
        case (NV_RSTCFG_I[2*i +: 2])
          RC_PU:
          begin
            port_drive_mode_reg[0][i] <= 1'b0;
            port_drive_mode_reg[1][i] <= 1'b1;
            port_drive_mode_reg[2][i] <= 1'b0;
            port_output_data_reg[i]   <= 1'b1;
          end
          RC_PD:
          begin
            port_drive_mode_reg[0][i] <= 1'b1;
            port_drive_mode_reg[1][i] <= 1'b1;
            port_drive_mode_reg[2][i] <= 1'b0;
            port_output_data_reg[i]   <= 1'b0;
          end
          default: ;
        endcase
      end
    end
    else if (WR_I)
    begin
      case (ADDR_I)
        OFF_DR:   port_output_data_reg   <= WDATA_I;
        OFF_DM0:  port_drive_mode_reg[0] <= WDATA_I;
        OFF_DM1:  port_drive_mode_reg[1] <= WDATA_I;
        OFF_DM2:  port_drive_mode_reg[2] <= WDATA_I;
        OFF_SLW:  port_slew_select_reg   <= WDATA_I;
        OFF_BYP:  byp                    <= WDATA_I;
        OFF_BIE:  bidir                  <= WDATA_I;
        OFF_IBD:  ibuf_dis               <= WDATA_I;
        OFF_CTL:  ctl                    <= WDATA_I;
        OFF_SIO:  reg_out                <= WDATA_I;
        default:
        begin
          if (pin_sel)
          begin
            port_drive_mode_reg[0][pin_idx] <= WDATA_I[PF_DM];
            port_drive_mode_reg[1][pin_idx] <= WDATA_I[PF_DM+1];
            port_drive_mode_reg[2][pin_idx] <= WDATA_I[PF_DM+2];
            port_output_data_reg[pin_idx]   <= WDATA_I[PF_DR];
            port_slew_select_reg[pin_idx]   <= WDATA_I[PF_SLW];
            byp[pin_idx]                    <= WDATA_I[PF_BYP];
            ibuf_dis[pin_idx]               <= WDATA_I[PF_IBD];
            bidir[pin_idx]                  <= WDATA_I[PF_BIE];
          end
        end
      endcase
    end
  end

  // reset configuration register, loaded from storage at release
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rstcfg <= 16'h0000;
    else if (!loaded)
      rstcfg <= NV_RSTCFG_I;
    else if (WR_I && ADDR_I == OFF_RSTCF)
      rstcfg[7:0] <= WDATA_I;
    // high byte sits under the regulated-output bits; not on the bus
  end

  // edge selects; like the port registers, deaf in the load cycle, which oe_sel is not
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ien0 <= RESET_BYTE;
      ien1 <= RESET_BYTE;
    end
    else if (loaded && WR_I && ADDR_I == OFF_IEN0)
      ien0 <= WDATA_I;
    else if (loaded && WR_I && ADDR_I == OFF_IEN1)
      ien1 <= WDATA_I;
  end

  // enable bus routing: one selector per pin
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_pin
      always_ff @(posedge REF_CLK_I or negedge RESETN_I)
      begin
        if (!RESETN_I)
          oe_sel[g] <= 4'h0;
        else if (WR_I && ADDR_I == OFF_OESEL + 6'(g))
          oe_sel[g] <= WDATA_I[3:0];
      end
      ppde_pin_drive u_drv (
        .mode_i      ({port_drive_mode_reg[2][g], port_drive_mode_reg[1][g],
                       port_drive_mode_reg[0][g]}),
        .data_i      (byp[g] ? BYPASS_DATA_I[g]
                             : port_output_data_reg[g]),
        .bidir_i     (bidir[g]),
        .oe_i        (AUX_OE_I[oe_sel[g]]),
        .ibuf_dis_i  (ibuf_dis[g]),
        .slow_i      (port_slew_select_reg[g]),
        .reg_out_i   (reg_out[g]),
        .strong_hi_o (sh[g]),
        .strong_lo_o (sl[g]),
        .res_hi_o    (rh[g]),
        .res_lo_o    (rl[g]),
        .in_en_o     (in_en[g]),
        .slow_o      (sw[g])
      );
      // edges only; a held level raises nothing
      always_comb
      begin
        case ({ien1[g], ien0[g]})
          EDGE_RISE: edge_hit[g] = pin_qq[g] == 1'b0 && pin_q[g] == 1'b1;
          EDGE_FALL: edge_hit[g] = pin_qq[g] == 1'b1 && pin_q[g] == 1'b0;
          EDGE_BOTH: edge_hit[g] = pin_qq[g] != pin_q[g];
          default:   edge_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // pin outputs; everything analog while reset or before load
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      STRONG_HI_O <= RESET_BYTE;
      STRONG_LO_O <= RESET_BYTE;
      RES_HI_O    <= RESET_BYTE;
      RES_LO_O    <= RESET_BYTE;
      SLOW_O      <= RESET_BYTE;
      LVTTL_O     <= 1'b0;
    end
    else
    begin
      STRONG_HI_O <= sh;
      STRONG_LO_O <= sl;
      RES_HI_O    <= rh;
      RES_LO_O    <= rl;
      SLOW_O      <= sw;
      LVTTL_O     <= ctl[CTL_LVTTL];
    end
  end

  // disabled input buffers read as zero
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pin_q      <= RESET_BYTE;
      pin_qq     <= RESET_BYTE;
      PIN_DATA_O <= RESET_BYTE;
    end
    else
    begin
      pin_q      <= PIN_I & in_en;
      pin_qq     <= pin_q;
      PIN_DATA_O <= PIN_I & in_en;
    end
  end

  // status: a new edge wins over the read clear
  always_comb
  begin
    next_stat = stat;
    if (stat_rd)
      next_stat = RESET_BYTE;
    next_stat = next_stat | edge_hit;
  end

  // no sleep input: edge logic always clocked
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      stat       <= RESET_BYTE;
      PORT_IRQ_O <= 1'b0;
    end
    else
    begin
      stat       <= next_stat;
      PORT_IRQ_O <= |next_stat;
    end
  end

  // read mux; anything unmapped reads as zero
  always_comb
  begin
    next_rdata = 8'h00;
    // pin form and selector pages decode on the upper address bits
    if (RD_I && ADDR_I[5:3] == OFF_PIN[5:3])
      next_rdata = {bidir[pin_idx], ibuf_dis[pin_idx], byp[pin_idx],
                    port_slew_select_reg[pin_idx],
                    port_output_data_reg[pin_idx],
                    port_drive_mode_reg[2][pin_idx],
                    port_drive_mode_reg[1][pin_idx],
                    port_drive_mode_reg[0][pin_idx]};
    else if (RD_I && ADDR_I[5:3] == OFF_OESEL[5:3])
      next_rdata = {4'h0, oe_sel[pin_idx]};
    else if (RD_I)
    begin
      case (ADDR_I)
        OFF_DR:    next_rdata = port_output_data_reg;
        OFF_DM0:   next_rdata = port_drive_mode_reg[0];
        OFF_DM1:   next_rdata = port_drive_mode_reg[1];
        OFF_DM2:   next_rdata = port_drive_mode_reg[2];
        OFF_SLW:   next_rdata = port_slew_select_reg;
        OFF_BYP:   next_rdata = byp;
        OFF_BIE:   next_rdata = bidir;
        OFF_IBD:   next_rdata = ibuf_dis;
        OFF_IEN0:  next_rdata = ien0;
        OFF_IEN1:  next_rdata = ien1;
        OFF_STAT:  next_rdata = stat;
        OFF_PS:    next_rdata = pin_q;
        OFF_CTL:   next_rdata = ctl;
        OFF_SIO:   next_rdata = reg_out;
        OFF_RSTCF: next_rdata = rstcfg[7:0];
        default:   next_rdata = 8'h00;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      RDATA_O <= 8'h00;
    else
      RDATA_O <= next_rdata;
  end
endmodule : ppde_port

/* tb/ppde_port_monitor.sv */
// assertion checker for the port drive and edge interrupt block
module ppde_port_monitor
  import ppde_pkg::*;
(
  // clock, reset and register port
  input wire logic            REF_CLK_I,
  input wire logic            RESETN_I,
  input wire logic [AW-1:0]   ADDR_I,
  input wire logic            WR_I,
  input wire logic            RD_I,
  input wire logic [DW-1:0]   RDATA_O,
  // pins and request
  input wire logic [NPIN-1:0] PIN_I,
  input wire logic [NPIN-1:0] STRONG_HI_O,
  input wire logic [NPIN-1:0] STRONG_LO_O,
  input wire logic [NPIN-1:0] RES_HI_O,
  input wire logic [NPIN-1:0] RES_LO_O,
  input wire logic [NPIN-1:0] SLOW_O,
  input wire logic            LVTTL_O,
  input wire logic [NPIN-1:0] PIN_DATA_O,
  input wire logic            PORT_IRQ_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire [NPIN-1:0] hi_side = STRONG_HI_O | RES_HI_O;
  wire [NPIN-1:0] lo_side = STRONG_LO_O | RES_LO_O;
  AST_ONE_DRIVE: assert property (
    ((hi_side & lo_side) | (STRONG_HI_O & RES_HI_O)
     | (STRONG_LO_O & RES_LO_O)) == '0)
    else $error("pin driven two ways");
  AST_SLOW_STRONG: assert property (
    (SLOW_O & ~(STRONG_HI_O | STRONG_LO_O)) == '0)
    else $error("slow slew without strong drive");
  AST_INPUT_GATE: assert property (
    (PIN_DATA_O & ~$past(PIN_I)) == '0)
    else $error("pin data not from pin");
  AST_IRQ_RISE: assert property (
    $rose(PORT_IRQ_O) |-> $past(PIN_I, 2) != $past(PIN_I, 3))
    else $error("request rose without edge");
  AST_IRQ_CLEAR: assert property (
    $fell(PORT_IRQ_O) |-> $past(RD_I) && $past(ADDR_I) == OFF_STAT)
    else $error("request fell without status read");
  AST_STAT_READ: assert property (
    RD_I && ADDR_I == OFF_STAT && PORT_IRQ_O |=> RDATA_O != '0)
    else $error("request pending, status empty");
  AST_RDATA_IDLE: assert property (
    !RD_I |=> RDATA_O == '0)
    else $error("read data outside read");
  AST_LVTTL_CAUSE: assert property (
    $changed(LVTTL_O) |-> ($past(WR_I) && $past(ADDR_I) == OFF_CTL)
    || ($past(WR_I, 2) && $past(ADDR_I, 2) == OFF_CTL))
    else $error("threshold changed without write");
  cover property ($rose(PORT_IRQ_O));
  cover property (|SLOW_O);
  cover property ($rose(LVTTL_O));
endmodule : ppde_port_monitor

bind ppde_port ppde_port_monitor i_ppde_port_monitor (
  .REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PIN_I(PIN_I),
  .STRONG_HI_O(STRONG_HI_O), .STRONG_LO_O(STRONG_LO_O),
  .RES_HI_O(RES_HI_O), .RES_LO_O(RES_LO_O), .SLOW_O(SLOW_O),
  .LVTTL_O(LVTTL_O), .PIN_DATA_O(PIN_DATA_O), .PORT_IRQ_O(PORT_IRQ_O));

/* tb/ppde_board.sv */
// board model: outside levels and loads on the port pins
module ppde_board
  import ppde_pkg::*;
(
  // port drive and outside source
  input  wire logic            clk_i,
  input  wire logic [NPIN-1:0] shi_i,
  input  wire logic [NPIN-1:0] slo_i,
  input  wire logic [NPIN-1:0] rhi_i,
  input  wire logic [NPIN-1:0] rlo_i,
  input  wire logic            ext_en_i,
  input  wire logic [NPIN-1:0] ext_i,
  // resolved levels
  output logic      [NPIN-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // undriven pins wander so a stale level never reads as valid
  logic [NPIN-1:0] wander = 8'h5A;
  always @(posedge clk_i)
    wander <= ~wander;
  // an outside source beats the 5K resistor, not strong drive
  always_comb
    for (int i = 0; i < NPIN; i++)
      if (shi_i[i] | slo_i[i])
        pin_o[i] = shi_i[i];
      else if (ext_en_i)
        pin_o[i] = ext_i[i];
      else if (rhi_i[i] | rlo_i[i])
        pin_o[i] = rhi_i[i];
      else
        pin_o[i] = wander[i];
endmodule : ppde_board

/* tb/test_port_pin_drive_and_edge_irq.sv */
// self-checking bench for the port drive and edge interrupt block
module test_port_pin_drive_and_edge_irq
  import ppde_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ext_en = 1'b1;
  logic [AW-1:0]     addr = '0;
  logic [DW-1:0]     wdata = '0;
  logic [2*NPIN-1:0] nv = 16'h0009;
  logic [NPIN-1:0]   byp = '0, ext_val = '0;
  logic [NOE-1:0]    aux = '0;
  logic [NPIN-1:0]   pin, shi, slo, rhi, rlo, slow, pdata;
  logic [DW-1:0]     rdata, got, v;
  logic              lvttl, irq;
  logic [7:0]        pv [4];
  logic [3:0]        e;
  int                failures, checks_done, p, k, s;
  ppde_port i_ppde_port (
    .REF_CLK_I(clk), .RESETN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .NV_RSTCFG_I(nv),
    .BYPASS_DATA_I(byp), .AUX_OE_I(aux), .PIN_I(pin),
    .STRONG_HI_O(shi), .STRONG_LO_O(slo), .RES_HI_O(rhi),
    .RES_LO_O(rlo), .SLOW_O(slow), .LVTTL_O(lvttl),
    .PIN_DATA_O(pdata), .PORT_IRQ_O(irq));
  ppde_board i_ppde_board (
    .clk_i(clk), .shi_i(shi), .slo_i(slo), .rhi_i(rhi), .rlo_i(rlo),
    .ext_en_i(ext_en), .ext_i(ext_val), .pin_o(pin));
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [AW-1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg
  // drive code {strong hi, strong lo, res hi, res lo}
  function automatic logic [3:0] exp_drv(input logic [2:0] m,
                                         input logic d);
    case (m)
      3'h2: return d ? 4'h2 : 4'h4;
      3'h3: return d ? 4'h8 : 4'h1;
      3'h4: return d ? 4'h0 : 4'h4;
      3'h5: return d ? 4'h8 : 4'h0;
      3'h6: return d ? 4'h8 : 4'h4;
      3'h7: return d ? 4'h2 : 4'h1;
      default: return 4'h0;
    endcase
  endfunction : exp_drv
  function automatic logic [7:0] drv(input int q);
    return {4'h0, shi[q], slo[q], rhi[q], rlo[q]};
  endfunction : drv
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(59));
    tick(20);
    chk(shi | slo | rhi | rlo, 8'h00);
    @(posedge clk);
    rstn <= 1'b1;
    tick(3);
    chk(drv(0), 8'h01);
    chk(drv(1), 8'h02);
    rd_reg(OFF_DM1);
    chk(got, 8'h03);
    rd_reg(6'h3F);
    chk(got, 8'h00);
    for (k = 0; k < 48; k++)
    begin
      p = $urandom_range(NPIN - 1);
      v = DW'($urandom) & 8'h7F;
      if (k < 16)
        v[3:0] = {k[0], k[3:1]};
      byp <= NPIN'($urandom);
      ext_val <= NPIN'($urandom);
      wr_reg(OFF_PIN + AW'(p), v);
      rd_reg(OFF_PIN + AW'(p));
      chk(got, v);
      tick(3);
      e = exp_drv(v[2:0], v[PF_BYP] ? byp[p] : v[PF_DR]);
      chk(drv(p), {4'h0, e});
      chk({7'h0, slow[p]},
          {7'h0, v[PF_SLW] & v[2] & (e[3] | e[2])});
      chk({7'h0, pdata[p]},
          {7'h0, pin[p] & (v[2:0] != 3'h0) & !v[PF_IBD]});
    end
    wr_reg(OFF_BYP, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        pv[j] = DW'($urandom);
        wr_reg(AW'((j + 1) % 4), pv[j]);
      end
      tick(3);
      for (int q = 0; q < NPIN; q++)
        chk(drv(q), {4'h0, exp_drv({pv[2][q], pv[1][q], pv[0][q]},
                                   pv[3][q])});
    end
    for (k = 0; k < 4; k++)
    begin
      p = $urandom_range(NPIN - 1);
      s = $urandom_range(NOE - 1);
      wr_reg(OFF_PIN + AW'(p), 8'h9E);
      wr_reg(OFF_OESEL + AW'(p), DW'(s));
      aux <= ~(16'h0001 << s);
      tick(3);
      chk(drv(p), 8'h00);
      aux <= 16'h0001 << s;
      tick(3);
      chk(drv(p), 8'h08);
      chk({7'h0, slow[p]}, 8'h01);
    end
    aux <= '0;
    wr_reg(OFF_PIN + AW'(p), 8'h0F);
    wr_reg(OFF_SIO, 8'h01 << p);
    tick(3);
    chk(drv(p), 8'h00);
    wr_reg(OFF_PIN + AW'(p), 8'h0E);
    tick(3);
    chk(drv(p), 8'h08);
    wr_reg(OFF_SIO, 8'h00);
    for (k = 1; k >= 0; k--)
    begin
      wr_reg(OFF_CTL, DW'(k));
      tick(2);
      chk({7'h0, lvttl}, DW'(k));
    end
    p = $urandom_range(NPIN - 1);
    ext_val <= '0;
    wr_reg(OFF_PIN + AW'(p), 8'h01);
    for (k = 0; k < 4; k++)
    begin
      wr_reg(OFF_IEN0, DW'(k % 2) << p);
      wr_reg(OFF_IEN1, DW'(k / 2) << p);
      tick(3);
      rd_reg(OFF_STAT);
      ext_val[p] <= 1'b1;
      tick(4);
      chk({7'h0, irq}, DW'(k % 2));
      rd_reg(OFF_PS);
      chk({7'h0, got[p]}, 8'h01);
      rd_reg(OFF_STAT);
      chk(got, DW'(k % 2) << p);
      tick(4);
      rd_reg(OFF_STAT);
      chk(got, 8'h00);
      ext_val[p] <= 1'b0;
      tick(4);
      rd_reg(OFF_STAT);
      chk(got, DW'(k / 2) << p);
      tick(1);
      chk({7'h0, irq}, 8'h00);
    end
    give_verdict();
  end
endmodule : test_port_pin_drive_and_edge_irq
